// ===== test/prm_periph_model.sv
// Behavioural peripherals and port drivers beside the routing matrix
`timescale 1ns/1ps
`default_nettype none
module prm_periph_model
    import prm_pkg::*;
(
    input  wire logic               mclk,
    input  wire logic               arst_n,
    output logic [NUM_PIN-1:0]      pinIn,
    output logic [NUM_PIN-1:0]      portLatch,
    output logic [NUM_PIN-1:0]      portDirectionBit,
    output logic [NUM_SRC-1:0]      srcOut,
    output logic [NUM_SRC-1:0]      srcOverride,
    output logic [NUM_SRC-1:0]      srcOverrideOe
);
    logic [31:0] patReg;
    // The pattern shifts one place every cycle, so a stale or misrouted bit shows within a few cycles
    always_ff @(posedge mclk or negedge arst_n)
        if (!arst_n) patReg <= 32'h1F2E3D4C;
        else patReg <= {patReg[30:0], patReg[31] ^ patReg[21] ^ patReg[1] ^ patReg[0]};
    assign pinIn            = patReg[17:0];
    assign portLatch        = patReg[31:14];
    assign portDirectionBit = patReg[24:7];
    assign srcOut           = patReg[29:0] ^ {patReg[1:0], patReg[31:4]};
    assign srcOverrideOe    = patReg[31:2];
    // Only the serial transmit/data and the two serial units take the driver
    assign srcOverride      = 30'h03CC0000;
endmodule
`default_nettype wire

// ===== test/prm_pin_route_assertions.sv
// Bus protocol and read-back checks at the ports of the routing matrix
`timescale 1ns/1ps
`default_nettype none
module prm_pin_route_assertions
    import prm_pkg::*;
(
    input wire logic              mclk,
    input wire logic              arst_n,
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready,
    input wire logic [1:0]        s_axi_bresp,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready,
    input wire logic [31:0]       s_axi_rdata
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    sequence arTake;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence wrTake;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    AST_SEL_UPPER_ZERO: assert property (arTake ##0 s_axi_araddr < 12'h0C8 |=>
        s_axi_rvalid && s_axi_rdata[31:5] == 27'h0) else $error("selector read upper bits set");
    AST_LOCK_UPPER_ZERO: assert property (arTake ##0 s_axi_araddr == 12'h100 |=>
        s_axi_rvalid && s_axi_rdata[31:1] == 31'h0) else $error("lock read upper bits set");
    AST_BAD_READ: assert property (arTake ##0 s_axi_araddr >= 12'h108 |=>
        s_axi_rdata == 32'h0) else $error("unmapped read data not zero");
    AST_RDATA_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped early");
    AST_BVALID_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped early");
    AST_WR_BLOCKED: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while answer pending");
    AST_WR_ANSWER: assert property (wrTake |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    AST_BAD_WRITE: assert property (wrTake ##0 s_axi_awaddr >= 12'h108 |-> ##2
        s_axi_bresp == RESP_SLVERR) else $error("unmapped write not refused");
endmodule
bind prm_pin_route prm_pin_route_assertions i_prm_pin_route_assertions (.mclk, .arst_n,
    .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);
`default_nettype wire

// ===== test/prm_pin_route_tb.sv
// Self-checking bench of the pin routing matrix
`timescale 1ns/1ps
`default_nettype none
module prm_pin_route_tb
    import prm_pkg::*;
;
    logic mclk = 1'b0, arst_n = 1'b0, oneShotLockOption = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [NUM_PIN-1:0] pinIn, portLatch, portDirectionBit, gd, ge;
    logic [NUM_SRC-1:0] srcOut, srcOverride, srcOverrideOe;
    logic [NUM_IN-1:0] periphIn;
    prm_pin_s [NUM_PIN-1:0] pinDrive;
    logic [4:0] inSel [NUM_IN];
    logic [4:0] outSel [NUM_PIN];
    int n_errors = 0, n_tests = 0;
    always #10 mclk = ~mclk;
    prm_pin_route i_prm_pin_route (.mclk, .arst_n, .s_axi_awvalid, .s_axi_awready,
        .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
        .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
        .oneShotLockOption, .pinIn, .portLatch, .portDirectionBit, .srcOut,
        .srcOverride, .srcOverrideOe, .periphIn, .pinDrive);
    prm_periph_model i_prm_periph_model (.mclk, .arst_n, .pinIn, .portLatch,
        .portDirectionBit, .srcOut, .srcOverride, .srcOverrideOe);
    task automatic chkVal(input string what, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        int t;
        t = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge mclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            t++;
        end
        while (s_axi_bvalid !== 1'b1 && t < 50);
        chkVal("bvalid", 32'h1, 32'(s_axi_bvalid));
        chkVal("bresp", (a < 12'h108) ? RESP_OKAY : RESP_SLVERR, 32'(s_axi_bresp));
        s_axi_bready <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        int t;
        t = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge mclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            t++;
        end
        while (s_axi_rvalid !== 1'b1 && t < 50);
        chkVal("rvalid", 32'h1, 32'(s_axi_rvalid));
        chkVal("rdata", e, s_axi_rdata);
        chkVal("rresp", (a < 12'h108) ? RESP_OKAY : RESP_SLVERR, 32'(s_axi_rresp));
        s_axi_rready <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic lockSeq(input logic [31:0] v);
        wr(12'h100, 32'h55);
        wr(12'h100, 32'hAA);
        wr(12'h100, v);
    endtask
    task automatic chkRoute(input int n);
        logic [17:0] pv, lv, dv, ed, ee;
        logic [29:0] sv, ov, oe;
        logic [28:0] ei;
        logic [4:0] c;
        repeat (n)
        begin
            @(negedge mclk);
            {pv, lv, dv, sv, ov, oe} = {pinIn, portLatch, portDirectionBit,
                srcOut, srcOverride, srcOverrideOe};
            @(posedge mclk);
            #1;
            for (int i = 0; i < NUM_IN; i++)
            begin
                c = inSel[i];
                ei[i] = (c <= 5 || (c >= 12 && c <= 23)) ? pv[(c < 6) ? c : c - 6] : 1'b0;
            end
            for (int p = 0; p < NUM_PIN; p++)
            begin
                c = outSel[p];
                ed[p] = (c < 2) ? lv[p] : sv[c - 2];
                ee[p] = (c >= 2 && ov[c - 2]) ? oe[c - 2] : !dv[p];
                gd[p] = pinDrive[p].drive;
                ge[p] = pinDrive[p].enable;
            end
            chkVal("periphIn", 32'(ei), 32'(periphIn));
            chkVal("drive", 32'(ed), 32'(gd));
            chkVal("enable", 32'(ee), 32'(ge));
        end
    endtask
    task automatic readAll;
        for (int i = 0; i < NUM_IN; i++) rd(12'(4 * i), 32'(inSel[i]));
        for (int p = 0; p < NUM_PIN; p++) rd(12'(128 + 4 * p), 32'(outSel[p]));
    endtask
    task automatic doReset;
        arst_n <= 1'b0;
        repeat (8) @(posedge mclk);
        arst_n <= 1'b1;
        foreach (inSel[i]) inSel[i] = 5'h00;
        foreach (outSel[p]) outSel[p] = 5'h00;
        @(posedge mclk);
    endtask
    initial
    begin
        #200000;
        n_errors++;
        tally_and_finish();
    end
    initial
    begin
        doReset();
        readAll();
        chkRoute(3);
        for (int i = 0; i < NUM_IN; i++)
        begin
            wr(12'(4 * i), 32'hE0 | i);
            inSel[i] = 5'(i);
        end
        for (int k = 0; k < 2; k++)
        begin
            for (int p = 0; p < NUM_PIN; p++)
            begin
                wr(12'(128 + 4 * p), 32'(p + 14 * k));
                outSel[p] = 5'(p + 14 * k);
            end
            chkRoute(4);
        end
        wr(12'h048, 32'h10);
        wr(12'h0A8, 32'h18);
        {inSel[18], outSel[10]} = {5'h10, 5'h18};
        chkRoute(2);
        readAll();
        lockSeq(32'h1);
        rd(12'h100, 32'h1);
        wr(12'h000, 32'h3);
        wr(12'h080, 32'h1);
        rd(12'h000, 32'(inSel[0]));
        rd(12'h080, 32'(outSel[0]));
        chkRoute(2);
        lockSeq(32'h0);
        rd(12'h100, 32'h0);
        wr(12'h100, 32'h55);
        wr(12'h004, 32'h9);
        inSel[1] = 5'h09;
        wr(12'h100, 32'hAA);
        wr(12'h100, 32'h1);
        rd(12'h100, 32'h0);
        wr(12'h100, 32'h55);
        wr(12'h100, 32'h1);
        rd(12'h100, 32'h0);
        lockSeq(32'h1);
        lockSeq(32'h0);
        rd(12'h100, 32'h0);
        lockSeq(32'h1);
        oneShotLockOption <= 1'b1;
        doReset();
        rd(12'h100, 32'h0);
        readAll();
        lockSeq(32'h1);
        lockSeq(32'h0);
        lockSeq(32'h1);
        rd(12'h100, 32'h0);
        rd(12'h104, 32'h7);
        wr(12'h008, 32'h5);
        rd(12'h008, 32'h5);
        s_axi_wstrb <= 4'hE;
        wr(12'h008, 32'h1F);
        s_axi_wstrb <= 4'hF;
        rd(12'h008, 32'h5);
        wr(12'h200, 32'h1);
        rd(12'h200, 32'h0);
        tally_and_finish();
    end
endmodule
`default_nettype wire

// ===== verilog/prm_pin_route.sv
// Peripheral pin routing matrix with AXI4-Lite register access
//
// Local design decisions: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module prm_pin_route
    import prm_pkg::*;
(
    input  wire logic                          mclk,
    input  wire logic                          arst_n,
    input  wire logic                          s_axi_awvalid,
    output var  logic                          s_axi_awready,
    input  wire logic [ADDR_W-1:0]             s_axi_awaddr,
    input  wire logic                          s_axi_wvalid,
    output var  logic                          s_axi_wready,
    input  wire logic [31:0]                   s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    output var  logic                          s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    output var  logic [1:0]                    s_axi_bresp,
    input  wire logic                          s_axi_arvalid,
    output var  logic                          s_axi_arready,
    input  wire logic [ADDR_W-1:0]             s_axi_araddr,
    output var  logic                          s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    output var  logic [31:0]                   s_axi_rdata,
    output var  logic [1:0]                    s_axi_rresp,
    input  wire logic                          oneShotLockOption,
    input  wire logic [NUM_PIN-1:0]            pinIn,
    input  wire logic [NUM_PIN-1:0]            portLatch,
    input  wire logic [NUM_PIN-1:0]            portDirectionBit,
    input  wire logic [NUM_SRC-1:0]            srcOut,
    input  wire logic [NUM_SRC-1:0]            srcOverride,
    input  wire logic [NUM_SRC-1:0]            srcOverrideOe,
    output var  logic [NUM_IN-1:0]             periphIn,
    output var  prm_pin_s [NUM_PIN-1:0]        pinDrive
);

    // Selectors: five bits each, upper bits do not exist
    logic [SEL_W-1:0] inSel_reg  [NUM_IN];
    logic [SEL_W-1:0] outSel_reg [NUM_PIN];

    logic             routeLocked_reg;
    logic             clrUsed_reg;
    logic             setUsed_reg;
    logic             oneShot_reg;
    prm_key_e         keyState_reg;
    prm_key_e         keyState_next;

    // Write and read channel holding registers
    logic              awHeld_reg;
    logic [IDX_W-1:0]  wrIdx_reg;
    logic              wHeld_reg;
    logic [7:0]        wrByte_reg;
    logic              wrLane_reg;
    logic              bvalid_reg;
    logic [1:0]        bresp_reg;
    logic              rvalid_reg;
    logic [31:0]       rdata_reg;
    logic [1:0]        rresp_reg;

    logic [NUM_IN-1:0]   periphIn_reg;
    prm_pin_s [NUM_PIN-1:0] pinDrive_reg;

    // Write decode
    // Ready already shuts each channel while a half is held or an answer waits
    wire              awFire   = s_axi_awvalid && s_axi_awready;
    wire              wFire    = s_axi_wvalid && s_axi_wready;
    wire              wrFire   = awHeld_reg && wHeld_reg && !bvalid_reg;
    wire [IDX_W-1:0]  wrOutOff = wrIdx_reg - OUT_IDX0;
    wire              wrInHit  = wrIdx_reg < IDX_W'(NUM_IN);
    wire              wrOutHit = wrIdx_reg >= OUT_IDX0 && wrOutOff < IDX_W'(NUM_PIN);
    wire              wrLockHit = wrIdx_reg == LOCK_IDX;
    wire              wrStatHit = wrIdx_reg == STAT_IDX;
    wire              wrMapped = wrInHit || wrOutHit || wrLockHit || wrStatHit;
    wire              selWrOk  = wrFire && wrLane_reg && !routeLocked_reg;
    wire              lockWr   = wrFire && wrLane_reg && wrLockHit;

    // Read decode
    wire              arFire   = s_axi_arvalid && s_axi_arready;
    wire [IDX_W-1:0]  rdIdx    = s_axi_araddr[ADDR_W-1:2];
    wire [IDX_W-1:0]  rdOutOff = rdIdx - OUT_IDX0;
    wire              rdInHit  = rdIdx < IDX_W'(NUM_IN);
    wire              rdOutHit = rdIdx >= OUT_IDX0 && rdOutOff < IDX_W'(NUM_PIN);
    wire              rdLockHit = rdIdx == LOCK_IDX;
    wire              rdStatHit = rdIdx == STAT_IDX;
    wire              rdMapped = rdInHit || rdOutHit || rdLockHit || rdStatHit;
    wire [SEL_W-1:0]  rdInVal  = rdInHit ? inSel_reg[rdIdx[SEL_W-1:0]] : '0;
    wire [SEL_W-1:0]  rdOutVal = rdOutHit ? outSel_reg[rdOutOff[SEL_W-1:0]] : '0;
    wire [3:0]        statWord = {keyState_reg == KEY_OPEN, setUsed_reg, clrUsed_reg,
                                  oneShot_reg};
    // Selectors read regardless of lock state; upper bits read zero
    wire [31:0]       rdInWord   = {27'h0, rdInVal};
    wire [31:0]       rdOutWord  = {27'h0, rdOutVal};
    wire [31:0]       rdLockWord = {31'h0, routeLocked_reg};
    wire [31:0]       rdStatWord = {28'h0, statWord};
    wire [31:0]       rdWord   = rdInHit   ? rdInWord
                               : rdOutHit  ? rdOutWord
                               : rdLockHit ? rdLockWord
                               : rdStatHit ? rdStatWord
                               : 32'h00000000;

    // Lock change qualification
    wire              newLock   = wrByte_reg[LOCK_BIT];
    wire              wantsChg  = newLock != routeLocked_reg;
    wire              chgUnused = newLock ? !setUsed_reg : !clrUsed_reg;
    wire              chgOk     = lockWr && keyState_reg == KEY_OPEN && wantsChg
                                  && (!oneShot_reg || chgUnused);

    // Key sequence: any other write breaks it
    always_comb
    begin
        keyState_next = keyState_reg;
        if (wrFire)
        begin
            if (!lockWr || keyState_reg == KEY_OPEN)
                keyState_next = KEY_IDLE;
            else if (wrByte_reg == KEY_FIRST)
                keyState_next = KEY_HALF;
            else if (keyState_reg == KEY_HALF && wrByte_reg == KEY_SECOND)
                keyState_next = KEY_OPEN;
            else
                keyState_next = KEY_IDLE;
        end
    end

    // Only the power-on reset reaches lock state and selectors; sleep does not
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            keyState_reg <= KEY_IDLE;
        else
            keyState_reg <= keyState_next;
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            routeLocked_reg <= 1'b0;
        else if (chgOk)
            routeLocked_reg <= newLock;
    end

    // Usage flags clear only at power-on, which is what makes the one-shot option stick
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            clrUsed_reg <= 1'b0;
            setUsed_reg <= 1'b0;
        end
        else if (chgOk)
        begin
            setUsed_reg <= setUsed_reg || newLock;
            clrUsed_reg <= clrUsed_reg || !newLock;
        end
    end

    // Option word is static; register it so logic sees a clean level
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            oneShot_reg <= 1'b0;
        else
            oneShot_reg <= oneShotLockOption;
    end

    // Pin level behind each input code; reserved codes read low
    wire [31:0] codeVec;

    genvar gc;
    generate
        for (gc = 0; gc < 32; gc++)
        begin : g_code
            if (gc <= 5)
            begin : g_port_a
                assign codeVec[gc] = pinIn[gc];
            end
            else if (gc >= 12 && gc <= 23)
            begin : g_port_bc
                assign codeVec[gc] = pinIn[gc - 6];
            end
            else
            begin : g_reserved
                assign codeVec[gc] = 1'b0;
            end
        end
    endgenerate

    // Input selectors and routing, one per peripheral input

    genvar gi;
    generate
        for (gi = 0; gi < NUM_IN; gi++)
        begin : g_in
            wire inWe = selWrOk && wrInHit && wrIdx_reg[SEL_W-1:0] == SEL_W'(gi);
            // Only bits 4-0 are stored, so bits 7-5 of the written byte vanish here
            always_ff @(posedge mclk or negedge arst_n)
            begin
                if (!arst_n)
                    inSel_reg[gi] <= IN_DEF[gi];
                else if (inWe)
                    inSel_reg[gi] <= wrByte_reg[SEL_W-1:0];
            end

            always_ff @(posedge mclk or negedge arst_n)
            begin
                if (!arst_n)
                    periphIn_reg[gi] <= 1'b0;
                else
                    periphIn_reg[gi] <= codeVec[inSel_reg[gi]];
            end
        end
    endgenerate

    // Output selectors and routing, one per pin; analog functions never enter here
    wire [31:0] srcVec = {srcOut, 2'h0};
    wire [31:0] ovrVec = {srcOverride, 2'h0};
    wire [31:0] ovrOeVec = {srcOverrideOe, 2'h0};

    genvar gp;
    generate
        for (gp = 0; gp < NUM_PIN; gp++)
        begin : g_pin
            wire [SEL_W-1:0] sel = outSel_reg[gp];
            wire outWe    = selWrOk && wrOutHit && wrOutOff[SEL_W-1:0] == SEL_W'(gp);
            wire reserved = sel < SRC_FIRST;
            // Source order by code: fixed by srcOut bit order
            wire drv      = reserved ? portLatch[gp] : srcVec[sel];
            wire ovr      = !reserved && ovrVec[sel];
            wire oe       = ovr ? ovrOeVec[sel] : !portDirectionBit[gp];
            // Selector and pin stage kept apart so a lock never stalls the routing
            always_ff @(posedge mclk or negedge arst_n)
            begin
                if (!arst_n)
                    outSel_reg[gp] <= OUT_DEF;
                else if (outWe)
                    outSel_reg[gp] <= wrByte_reg[SEL_W-1:0];
            end

            always_ff @(posedge mclk or negedge arst_n)
            begin
                if (!arst_n)
                    pinDrive_reg[gp] <= '0;
                else
                    pinDrive_reg[gp] <= '{drive: drv, enable: oe};
            end
        end
    endgenerate

    // Address half of a write, held until the data half has joined it
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            awHeld_reg <= 1'b0;
            wrIdx_reg  <= '0;
        end
        else if (awFire)
        begin
            awHeld_reg <= 1'b1;
            wrIdx_reg  <= s_axi_awaddr[ADDR_W-1:2];
        end
        else if (wrFire)
            awHeld_reg <= 1'b0;
    end

    // Data half of a write; only the low byte lane carries selector bits
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wHeld_reg  <= 1'b0;
            wrByte_reg <= '0;
            wrLane_reg <= 1'b0;
        end
        else if (wFire)
        begin
            wHeld_reg  <= 1'b1;
            wrByte_reg <= s_axi_wdata[7:0];
            wrLane_reg <= s_axi_wstrb[0];
        end
        else if (wrFire)
            wHeld_reg <= 1'b0;
    end

    // Write answer stands until the master takes it
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= RESP_OKAY;
        end
        else if (wrFire)
        begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wrMapped ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_bready)
            bvalid_reg <= 1'b0;
    end

    // Read path: one-cycle answer that stands until rready
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            rvalid_reg <= 1'b0;
        else if (arFire)
            rvalid_reg <= 1'b1;
        else if (s_axi_rready)
            rvalid_reg <= 1'b0;
    end

    // Data is captured only with the address, so it cannot move while it stands
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rdata_reg <= '0;
            rresp_reg <= RESP_OKAY;
        end
        else if (arFire)
        begin
            rdata_reg <= rdWord;
            rresp_reg <= rdMapped ? RESP_OKAY : RESP_SLVERR;
        end
    end

    // Ready outputs registered so they come from flip-flops
    logic awReady_reg;
    logic wReady_reg;
    logic arReady_reg;
    // A channel stays shut from its own take until the answer has gone
    wire  awReady_next = !(awHeld_reg || awFire) && !(bvalid_reg || wrFire);
    wire  wReady_next  = !(wHeld_reg || wFire) && !(bvalid_reg || wrFire);
    wire  arReady_next = !(rvalid_reg || arFire) || (rvalid_reg && s_axi_rready);

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            awReady_reg <= 1'b0;
        else
            awReady_reg <= awReady_next;
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            wReady_reg <= 1'b0;
        else
            wReady_reg <= wReady_next;
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            arReady_reg <= 1'b0;
        else
            arReady_reg <= arReady_next;
    end

    assign s_axi_awready = awReady_reg;
    assign s_axi_wready  = wReady_reg;
    assign s_axi_arready = arReady_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;
    assign periphIn      = periphIn_reg;
    assign pinDrive      = pinDrive_reg;

endmodule
`default_nettype wire

// ===== verilog/prm_pkg.sv
// Constants, types and register map of the peripheral pin routing matrix
package prm_pkg;

    localparam int NUM_IN  = 29;
    localparam int NUM_PIN = 18;
    localparam int NUM_SRC = 30;
    localparam int SEL_W   = 5;
    localparam int ADDR_W  = 12;
    localparam int IDX_W   = 10;

    // Word indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IN_IDX0  = 10'h000;
    localparam logic [IDX_W-1:0] OUT_IDX0 = 10'h020;
    localparam logic [IDX_W-1:0] LOCK_IDX = 10'h040;
    localparam logic [IDX_W-1:0] STAT_IDX = 10'h041;

    localparam logic [7:0] KEY_FIRST  = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;

    localparam int LOCK_BIT     = 0;
    localparam int STAT_ONESHOT = 0;
    localparam int STAT_CLRUSED = 1;
    localparam int STAT_SETUSED = 2;
    localparam int STAT_KEYOPEN = 3;

    localparam logic [SEL_W-1:0] SRC_FIRST = 5'h02;
    localparam logic [SEL_W-1:0] OUT_DEF   = 5'h00;
    // Per-peripheral input defaults
    localparam logic [NUM_IN-1:0][SEL_W-1:0] IN_DEF = '0;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {KEY_IDLE, KEY_HALF, KEY_OPEN} prm_key_e;

    typedef struct packed {
        logic drive;
        logic enable;
    } prm_pin_s;

endpackage
